// >>> ccu_monitor.sv
// assertion checker for the capture/compare unit bus and event outputs
`timescale 1ns/1ns
`default_nettype none
module ccu_monitor
    import ccu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic timer_clear,
    input wire logic unit_irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic req;
    logic irq_ack;
    assign req = avs_read || avs_write;
    assign irq_ack = avs_write && !avs_waitrequest && (avs_address == 5'h10);

    property p_wait_one;
        req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after request");
    property p_wait_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");
    property p_wait_req;
        !avs_waitrequest |-> $past(req);
    endproperty
    a_wait_req: assert property (p_wait_req) else $error("answer without request");
    property p_rd_hi_zero;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000;
    endproperty
    a_rd_hi_zero: assert property (p_rd_hi_zero) else $error("read data above byte");
    property p_rd_unmapped;
        avs_read && !avs_waitrequest && avs_address > 5'h14 |-> avs_readdata == 32'h00000000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_stand;
        $changed(avs_readdata) |-> $past(avs_read);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved without read");
    // only a software write to the irq register may drop the request
    property p_irq_hold;
        unit_irq && !irq_ack && !$past(irq_ack) |=> unit_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by hardware");
    property p_clr_gap;
        timer_clear |=> !timer_clear [*3];
    endproperty
    a_clr_gap: assert property (p_clr_gap) else $error("timer clear repeated");

    cover property (timer_clear);
    cover property ($rose(unit_irq));
    cover property (irq_ack);
endmodule
`default_nettype wire

// >>> ccu_params.svh
// register offsets, field positions, reset values and mode codes of the capture/compare unit
`ifndef CCU_PARAMS_SVH
`define CCU_PARAMS_SVH

`define CCU_OFF_CTRL 5'h00
`define CCU_OFF_CAPSEL 5'h04
`define CCU_OFF_VAL_LO 5'h08
`define CCU_OFF_VAL_HI 5'h0C
`define CCU_OFF_IRQ 5'h10
`define CCU_OFF_STAT 5'h14

`define CCU_CTRL_EN 7
`define CCU_CTRL_OD 5
`define CCU_CTRL_MODE_HI 3
`define CCU_CTRL_RST 8'h00

`define CCU_SEL_SRC_HI 1
`define CCU_SEL_TMR 4
`define CCU_SEL_RST 8'h00

`define CCU_IRQ_FLAG 0
`define CCU_IRQ_EN 1

`define CCU_MODE_OFF 4'h0
`define CCU_MODE_TGL_CLR 4'h1
`define CCU_MODE_TGL 4'h2
`define CCU_MODE_CAP_BOTH 4'h3
`define CCU_MODE_CAP_FALL 4'h4
`define CCU_MODE_CAP_RISE 4'h5
`define CCU_MODE_CAP_R4 4'h6
`define CCU_MODE_CAP_R16 4'h7
`define CCU_MODE_SET 4'h8
`define CCU_MODE_CLR 4'h9
`define CCU_MODE_PULSE 4'hA
`define CCU_MODE_PULSE_CLR 4'hB

`define CCU_PRESC_4_LAST 4'h3
`define CCU_PRESC_16_LAST 4'hF
`define CCU_WAIT_RST 1'b1

`endif

// >>> ccu_pkg.sv
// types shared by the capture/compare unit files
package ccu_pkg;
    typedef logic [15:0] ccu_word_t;
    typedef logic [3:0] ccu_mode_t;
    typedef enum logic [2:0] {
        CCU_EV_NONE,
        CCU_EV_FALL,
        CCU_EV_RISE,
        CCU_EV_RISE4,
        CCU_EV_RISE16,
        CCU_EV_BOTH
    } ccu_evsel_t;
    typedef enum logic [1:0] {
        CCU_CLS_OFF,
        CCU_CLS_CAPTURE,
        CCU_CLS_COMPARE,
        CCU_CLS_PWM
    } ccu_class_t;
endpackage

// >>> ccu_timer_model.sv
// shared timer model counting on the instruction clock, cleared on request
`timescale 1ns/1ns
`default_nettype none
module ccu_timer_model
    import ccu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic timer_clear,
    output ccu_word_t count_q
);
    logic [1:0] tick_q;
    // synchronous timer mode, one increment per four system clocks
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_q <= 2'h0;
            count_q <= 16'h0000;
        end else if (restart || timer_clear) begin
            tick_q <= 2'h0;
            count_q <= 16'h0000;
        end else begin
            tick_q <= tick_q + 2'h1;
            if (tick_q == 2'h3) begin
                count_q <= count_q + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> ccu_top.sv
// capture/compare unit with avalon-mm register slave
//
// Functional notes
// - value kept as separately addressable low and high byte registers.
// - capture counts come from a 16-bit odd-numbered timer.
// - several units may share one timer when in the same class.
// - output modes allow open-drain drive instead of push-pull.
// - each qualifying capture event copies the full timer count.
// - events are falling, rising, 4th rising, 16th rising, or any edge.
// - capture sets the irq flag; only software clears it.
// - a new capture overwrites an unread value.
// - capture source is chosen by a source selection field.
// - in capture mode the pin is an input; driven pin may trigger.
// - mode change may set the flag spuriously; software clears it.
// - prescaler cleared when off, not capturing, or on reset.
// - direct prescaler change keeps count; software writes zero first.
// - in sleep capture runs only with an externally clocked timer.
// - compare mode matches value against the selected timer count.
// - match toggles, sets, clears or pulses output, optionally clearing timer.
// - every compare mode raises the flag; modes 1 and 11 clear timer.
// - writing zero to control forces the compare latch low.
// - unit output is routed internally for other peripherals.
// - first timer is the default capture/compare time base.
//
// Design decisions made here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "ccu_params.svh"
module ccu_top
    import ccu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic unit_pin_in,
    output logic unit_pin_out,
    output logic unit_pin_oe_n,
    input wire logic pin_direction_bit,
    input wire logic [2:0] capture_alt_in,
    input wire ccu_word_t first_timer_count,
    input wire ccu_word_t third_timer_count,
    input wire logic timer_ext_clk,
    input wire logic sleep_mode,
    output logic timer_clear,
    output logic unit_out,
    output logic unit_irq
);
    logic [7:0] ctrl_q;
    logic [7:0] capsel_q;
    logic irq_flag_q;
    logic irq_en_q;
    logic ack_q;
    logic [2:0] sync_q;
    logic pin_level_q;
    logic src_prev_q;
    logic [3:0] presc_q;
    logic match_prev_q;
    logic latch_q;
    logic pulse_q;
    ccu_word_t value_q;

    logic access;
    logic wr_take;
    logic wr_ok;
    logic src_level;
    logic rise;
    logic fall;
    logic cap_event;
    logic cap_allowed;
    logic match;
    logic match_edge;
    logic wr_lo;
    logic wr_hi;
    logic irq_clear;
    ccu_mode_t mode;
    ccu_class_t cls;
    ccu_evsel_t evsel;
    ccu_word_t timer_sel;
    logic [7:0] rd_byte;

    // operating class of a mode code; PWM codes only decide the pin driver here
    function automatic ccu_class_t mode_class(input ccu_mode_t m);
        ccu_class_t c;
        c = CCU_CLS_OFF;
        case (m)
            `CCU_MODE_OFF: c = CCU_CLS_OFF;
            `CCU_MODE_CAP_BOTH, `CCU_MODE_CAP_FALL, `CCU_MODE_CAP_RISE,
            `CCU_MODE_CAP_R4, `CCU_MODE_CAP_R16: c = CCU_CLS_CAPTURE;
            `CCU_MODE_TGL_CLR, `CCU_MODE_TGL, `CCU_MODE_SET, `CCU_MODE_CLR,
            `CCU_MODE_PULSE, `CCU_MODE_PULSE_CLR: c = CCU_CLS_COMPARE;
            default: c = CCU_CLS_PWM;
        endcase
        return c;
    endfunction

    // capture event kind of a mode code
    function automatic ccu_evsel_t mode_event(input ccu_mode_t m);
        ccu_evsel_t e;
        e = CCU_EV_NONE;
        case (m)
            `CCU_MODE_CAP_FALL: e = CCU_EV_FALL;
            `CCU_MODE_CAP_RISE: e = CCU_EV_RISE;
            `CCU_MODE_CAP_R4: e = CCU_EV_RISE4;
            `CCU_MODE_CAP_R16: e = CCU_EV_RISE16;
            `CCU_MODE_CAP_BOTH: e = CCU_EV_BOTH;
            default: e = CCU_EV_NONE;
        endcase
        return e;
    endfunction

    assign mode = ctrl_q[`CCU_CTRL_MODE_HI:0];
    assign cls = ctrl_q[`CCU_CTRL_EN] ? mode_class(mode) : CCU_CLS_OFF;
    assign evsel = mode_event(mode);

    // ---------------- avalon-mm slave ----------------
    // one wait state: data prepared in the first cycle, taken in the second
    assign access = avs_read || avs_write;
    assign wr_take = avs_write && !avs_waitrequest;
    assign wr_ok = wr_take && avs_byteenable[0];
    assign wr_lo = wr_ok && (avs_address == `CCU_OFF_VAL_LO);
    assign wr_hi = wr_ok && (avs_address == `CCU_OFF_VAL_HI);
    assign irq_clear = wr_ok && (avs_address == `CCU_OFF_IRQ)
        && avs_writedata[`CCU_IRQ_FLAG];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= `CCU_WAIT_RST;
            ack_q <= 1'b0;
        end else if (access && avs_waitrequest && !ack_q) begin
            avs_waitrequest <= 1'b0;
            ack_q <= 1'b1;
        end else begin
            avs_waitrequest <= 1'b1;
            ack_q <= 1'b0;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        case (avs_address)
            `CCU_OFF_CTRL: rd_byte = ctrl_q;
            `CCU_OFF_CAPSEL: rd_byte = capsel_q;
            `CCU_OFF_VAL_LO: rd_byte = value_q[7:0];
            `CCU_OFF_VAL_HI: rd_byte = value_q[15:8];
            `CCU_OFF_IRQ: rd_byte = {6'h00, irq_en_q, irq_flag_q};
            `CCU_OFF_STAT: rd_byte = {presc_q, 1'b0, src_level, pin_level_q, latch_q};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest && !ack_q) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // ---------------- configuration registers ----------------
    // mode changes take effect as written: a direct switch keeps the prescaler
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `CCU_CTRL_RST;
        end else if (wr_ok && (avs_address == `CCU_OFF_CTRL)) begin
            ctrl_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            capsel_q <= `CCU_SEL_RST;
        end else if (wr_ok && (avs_address == `CCU_OFF_CAPSEL)) begin
            capsel_q <= avs_writedata[7:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_q <= 1'b0;
        end else if (wr_ok && (avs_address == `CCU_OFF_IRQ)) begin
            irq_en_q <= avs_writedata[`CCU_IRQ_EN];
        end
    end

    // ---------------- capture input ----------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_q <= 3'h0;
        end else begin
            sync_q <= {sync_q[1:0], unit_pin_in};
        end
    end

    // level changes only once the last two stages agree
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_level_q <= 1'b0;
        end else if (sync_q[1] == sync_q[2]) begin
            pin_level_q <= sync_q[2];
        end
    end

    // source 0 is the pin; others are on-chip signals already on this clock
    always_comb begin
        case (capsel_q[`CCU_SEL_SRC_HI:0])
            2'h0: src_level = pin_level_q;
            2'h1: src_level = capture_alt_in[0];
            2'h2: src_level = capture_alt_in[1];
            default: src_level = capture_alt_in[2];
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            src_prev_q <= 1'b0;
        end else begin
            src_prev_q <= src_level;
        end
    end

    assign rise = src_level && !src_prev_q;
    assign fall = !src_level && src_prev_q;
    assign cap_allowed = (cls == CCU_CLS_CAPTURE)
        && (!sleep_mode || timer_ext_clk);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= 4'h0;
        end else if (cls != CCU_CLS_CAPTURE) begin
            presc_q <= 4'h0;
        end else if (cap_allowed && rise) begin
            presc_q <= presc_q + 4'h1;
        end
    end

    always_comb begin
        case (evsel)
            CCU_EV_FALL: cap_event = fall;
            CCU_EV_RISE: cap_event = rise;
            CCU_EV_RISE4: cap_event = rise && (presc_q[1:0] == 2'(`CCU_PRESC_4_LAST));
            CCU_EV_RISE16: cap_event = rise && (presc_q == `CCU_PRESC_16_LAST);
            CCU_EV_BOTH: cap_event = rise || fall;
            default: cap_event = 1'b0;
        endcase
    end

    // first timer unless the third is selected; units read it in common
    assign timer_sel = capsel_q[`CCU_SEL_TMR] ? third_timer_count
        : first_timer_count;

    ccu_value_regs u_value (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .wr_lo(wr_lo),
        .wr_hi(wr_hi),
        .wdata(avs_writedata[7:0]),
        .cap_load(cap_allowed && cap_event),
        .cap_data(timer_sel),
        .value_q(value_q)
    );

    // ---------------- compare ----------------
    // act once per match: the timer may stay equal for several clocks
    assign match = (cls == CCU_CLS_COMPARE) && (value_q == timer_sel);
    assign match_edge = match && !match_prev_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            match_prev_q <= 1'b0;
        end else begin
            match_prev_q <= match;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            latch_q <= 1'b0;
        end else if (wr_ok && (avs_address == `CCU_OFF_CTRL)
                && (avs_writedata[7:0] == 8'h00)) begin
            latch_q <= 1'b0;
        end else if (match_edge) begin
            case (mode)
                `CCU_MODE_TGL_CLR, `CCU_MODE_TGL: latch_q <= !latch_q;
                `CCU_MODE_SET: latch_q <= 1'b1;
                `CCU_MODE_CLR: latch_q <= 1'b0;
                default: latch_q <= latch_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= match_edge && ((mode == `CCU_MODE_PULSE)
                || (mode == `CCU_MODE_PULSE_CLR));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_clear <= 1'b0;
        end else begin
            timer_clear <= match_edge && ((mode == `CCU_MODE_TGL_CLR)
                || (mode == `CCU_MODE_PULSE_CLR));
        end
    end

    // ---------------- flag and outputs ----------------
    // a new event in the clearing cycle keeps the flag set
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag_q <= 1'b0;
        end else if ((cap_allowed && cap_event) || match_edge) begin
            irq_flag_q <= 1'b1;
        end else if (irq_clear) begin
            irq_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_irq <= 1'b0;
        end else begin
            unit_irq <= irq_flag_q && irq_en_q;
        end
    end

    // pulse output uses the pulse stage, other modes the latch
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_out <= 1'b0;
        end else begin
            unit_out <= pulse_q || latch_q;
        end
    end

    // open drain only pulls low; capture mode never drives the pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            unit_pin_out <= 1'b0;
            unit_pin_oe_n <= 1'b1;
        end else begin
            unit_pin_out <= ctrl_q[`CCU_CTRL_OD] ? 1'b0 : (pulse_q || latch_q);
            unit_pin_oe_n <= !(((cls == CCU_CLS_COMPARE) || (cls == CCU_CLS_PWM))
                && !pin_direction_bit
                && (!ctrl_q[`CCU_CTRL_OD] || !(pulse_q || latch_q)));
        end
    end
endmodule
`default_nettype wire

// >>> ccu_value_regs.sv
// capture/compare value held as two byte registers with capture load
`timescale 1ns/1ns
`default_nettype none
module ccu_value_regs
    import ccu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    input wire logic cap_load,
    input wire ccu_word_t cap_data,
    output ccu_word_t value_q
);
    // capture overwrites whatever software has not read yet
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_q <= 16'h0000;
        end else if (cap_load) begin
            value_q <= cap_data;
        end else begin
            if (wr_lo) begin
                value_q[7:0] <= wdata;
            end
            if (wr_hi) begin
                value_q[15:8] <= wdata;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test_capture_compare_unit.sv
// self-checking bench for the capture/compare unit
`timescale 1ns/1ns
`default_nettype none
module test_capture_compare_unit
    import ccu_pkg::*;
();
    logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest, unit_pin_in, unit_pin_out;
    logic unit_pin_oe_n, pin_direction_bit, timer_ext_clk, sleep_mode, timer_clear, unit_out;
    logic unit_irq, restart, saw_clr, saw_hi, blk;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [2:0] capture_alt_in;
    ccu_word_t first_timer_count, third_timer_count, base, v, e;
    integer seed = 32'h9D15F70A;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    logic [3:0] cap_m [0:6] = '{4'h4, 4'h5, 4'h3, 4'h6, 4'h7, 4'h5, 4'h5};
    logic [3:0] cmp_m [0:5] = '{4'h1, 4'h2, 4'h9, 4'hA, 4'hB, 4'h8};

    ccu_top uut (.core_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .unit_pin_in, .unit_pin_out,
        .unit_pin_oe_n, .pin_direction_bit, .capture_alt_in, .first_timer_count,
        .third_timer_count, .timer_ext_clk, .sleep_mode, .timer_clear, .unit_out, .unit_irq);
    ccu_timer_model tmr (.core_clk, .rst_n, .restart, .timer_clear, .count_q(first_timer_count));

    always #5 core_clk = ~core_clk;

    task automatic print_verdict();
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        chk(n < 50, 1'b1);
    endtask

    task automatic rc(input logic [4:0] a, input logic [31:0] x);
        bus(1'b0, a, 8'h00);
        chk(q, x);
    endtask

    // index of the last pin step that should have captured
    function automatic int exp_k(input logic [3:0] m);
        case (m)
            4'h3, 4'h4: return 41;
            4'h5: return 40;
            4'h6: return 38;
            default: return 30;
        endcase
    endfunction

    initial begin
        {rst_n, avs_read, avs_write, unit_pin_in, pin_direction_bit} = '0;
        {timer_ext_clk, sleep_mode, restart, core_clk} = '0;
        avs_address = 5'h00;
        avs_writedata = 32'h00000000;
        third_timer_count = 16'h0000;
        capture_alt_in = 3'h0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 32; a += 4) rc(5'(a), 32'h00000000);
        pin_direction_bit <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            base = 16'($random(seed));
            sleep_mode <= (i > 4);
            timer_ext_clk <= (i == 6);
            blk = (i == 5);
            bus(1'b1, 5'h00, 8'h00);
            bus(1'b1, 5'h04, (i == 2) ? 8'h11 : 8'h10);
            bus(1'b1, 5'h08, 8'hEE);
            bus(1'b1, 5'h0C, 8'hEE);
            bus(1'b1, 5'h00, {4'h8, cap_m[i]});
            bus(1'b1, 5'h10, 8'h01);
            for (int k = 0; k < 42; k++) begin
                @(posedge core_clk);
                third_timer_count <= base + 16'(k);
                unit_pin_in <= (k % 2 == 0);
                capture_alt_in <= {2'b00, (k % 2 == 0)};
                repeat (8) @(posedge core_clk);
            end
            e = blk ? 16'hEEEE : base + 16'(exp_k(cap_m[i]));
            rc(5'h08, {24'h000000, e[7:0]});
            rc(5'h0C, {24'h000000, e[15:8]});
            rc(5'h08, {24'h000000, e[7:0]});
            rc(5'h10, {31'h00000000, !blk});
        end
        sleep_mode <= 1'b0;
        pin_direction_bit <= 1'b0;
        bus(1'b1, 5'h04, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 16'h0040 + 16'($random(seed) & 31);
            bus(1'b1, 5'h00, 8'h00);
            bus(1'b0, 5'h14, 8'h00);
            chk(q[0], 1'b0);
            bus(1'b1, 5'h08, v[7:0]);
            bus(1'b1, 5'h0C, v[15:8]);
            bus(1'b1, 5'h10, 8'h03);
            restart <= 1'b1;
            @(posedge core_clk);
            restart <= 1'b0;
            bus(1'b1, 5'h00, {4'h8, cmp_m[i]});
            saw_clr = 1'b0;
            saw_hi = 1'b0;
            repeat (400) begin
                @(posedge core_clk);
                saw_clr |= timer_clear;
                saw_hi |= unit_out;
            end
            chk(saw_clr, cmp_m[i] == 4'h1 || cmp_m[i] == 4'hB);
            chk(saw_hi, cmp_m[i] != 4'h9);
            chk(unit_irq, 1'b1);
        end
        chk({unit_pin_oe_n, unit_pin_out}, 2'b01);
        bus(1'b1, 5'h00, 8'hA8);
        repeat (3) @(posedge core_clk);
        chk({unit_pin_oe_n, unit_pin_out}, 2'b10);
        print_verdict();
    end
endmodule

bind ccu_top ccu_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timer_clear(timer_clear), .unit_irq(unit_irq));
`default_nettype wire
